/* tcc_pkg.sv */
// Purpose: Shared constants and types of the temperature conversion control block
// Assumes: 100 MHz core clock
// Notes: Register offsets, field positions, reset values and timing constants
package tcc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] TCC_OFS_CTRL = 8'h2A; // measure_control
  localparam logic [7:0] TCC_OFS_RES_HI = 8'h2B; // thermal_result_high
  localparam logic [7:0] TCC_OFS_RES_LO = 8'h2C; // thermal_result_low
  localparam int TCC_BIT_GO = 0; // Measurement go bit
  localparam int TCC_BIT_AUTO = 1; // Continuous-sampling select
  localparam logic TCC_CTRL_RST = 1'b0; // Reset of both control bits
  localparam int TCC_DATA_W = 16; // Result width
  localparam logic [15:0] TCC_RESULT_RST = 16'h0000; // Result reset value
  localparam logic [7:0] TCC_RD_ZERO = 8'h00; // Answer for unowned offsets
  // ----------------------------------------------------------------
  // Sample interval timing
  // ----------------------------------------------------------------
  localparam int TCC_CODE_W = 4; // Sample interval code width
  localparam int TCC_CLK_PERIOD_NS = 10; // Core clock period
  localparam longint TCC_TICK_NS = 125_000_000; // Base period 0.125 s
  localparam int TCC_TICK_CYCLES = int'(TCC_TICK_NS / TCC_CLK_PERIOD_NS);
  localparam int TCC_TICKS_W = 10; // Width of base-period count
  localparam logic [9:0] TCC_TICKS_SLOWEST = 10'h200; // Code 0: 64 s
  localparam logic [9:0] TCC_TICKS_FASTEST = 10'h001; // Codes 9 and up
  localparam logic [3:0] TCC_CODE_FASTEST = 4'h9; // First fastest code
  // ----------------------------------------------------------------
  // Control states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TCC_ST_IDLE = 3'b000, // Nothing running
    TCC_ST_SINGLE = 3'b001, // Single-shot conversion
    TCC_ST_AUTO_RUN = 3'b010, // Periodic conversion running
    TCC_ST_AUTO_WAIT = 3'b011, // Waiting for next period
    TCC_ST_EXT_RUN = 3'b100 // Pin-triggered conversion
  } tcc_state_t;
endpackage : tcc_pkg

/* tcc_conv_if.sv */
// Purpose: Carrier between the control logic and the conversion engine
// Assumes: Single clock domain
// Notes: start and abort are one-cycle pulses, done is a one-cycle pulse
interface tcc_conv_if;
  logic start; // Begin one conversion
  logic abort; // Drop the running conversion
  logic busy; // Engine converting
  logic done; // Conversion finished, data valid
  logic [15:0] data; // Converted sample
  modport ctrl (output start, output abort, input busy, input done, input data);
  modport engine (input start, input abort, output busy, output done, output data);
endinterface : tcc_conv_if

/* tcc_conv_engine.sv */
// Purpose: Drives the analog front end through one conversion at a time
// Assumes: Front end is on the same clock and answers with a done pulse
// Notes: An abort in the cycle of fe_done discards that sample
module tcc_conv_engine (
  input wire logic clk,
  input wire logic rst_n,
  tcc_conv_if.engine cv,
  output logic fe_start,
  output logic fe_abort,
  input wire logic fe_done,
  input wire logic [15:0] fe_data
);
  import tcc_pkg::*;

  logic busy_ff, nxt_busy; // Conversion outstanding
  logic done_ff, nxt_done; // Sample handed up
  logic [15:0] data_ff, nxt_data; // Captured sample
  logic start_ff, nxt_start; // Start pulse to front end
  logic abort_ff, nxt_abort; // Abort pulse to front end

  // Next values of the engine
  always_comb begin
    nxt_start = cv.start;
    nxt_abort = cv.abort && (busy_ff || cv.start);
    nxt_done = busy_ff && fe_done && !cv.abort;
    nxt_data = nxt_done ? fe_data : data_ff;
    if (cv.abort) begin
      nxt_busy = 1'b0; // Abort wins
    end else if (cv.start) begin
      nxt_busy = 1'b1;
    end else if (fe_done) begin
      nxt_busy = 1'b0;
    end else begin
      nxt_busy = busy_ff;
    end
  end

  // Engine registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      data_ff <= TCC_RESULT_RST;
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      data_ff <= nxt_data;
      start_ff <= nxt_start;
      abort_ff <= nxt_abort;
    end
  end

  assign cv.busy = busy_ff;
  assign cv.done = done_ff;
  assign cv.data = data_ff;
  assign fe_start = start_ff;
  assign fe_abort = abort_ff;
endmodule : tcc_conv_engine

/* tcc_interval_timer.sv */
// Purpose: Measures the sample period of continuous sampling
// Assumes: load is a pulse at the start of each periodic conversion
// Notes: expired stays high until the next load
module tcc_interval_timer #(
  parameter int TICK_CYCLES = tcc_pkg::TCC_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [3:0] code,
  output logic expired
);
  import tcc_pkg::*;
  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  logic [PRE_W-1:0] pre_ff, nxt_pre; // Cycles within one base period
  logic [TCC_TICKS_W-1:0] ticks_ff, nxt_ticks; // Base periods left
  logic run_ff, nxt_run; // Timer running
  logic exp_ff, nxt_exp; // Period elapsed

  // Next values of the timer
  always_comb begin
    nxt_pre = pre_ff;
    nxt_ticks = ticks_ff;
    nxt_run = run_ff;
    nxt_exp = exp_ff;
    if (load) begin
      nxt_pre = '0;
      nxt_run = 1'b1;
      nxt_exp = 1'b0;
      // Each code step halves the period, fastest from code 9 up
      nxt_ticks = (code >= TCC_CODE_FASTEST) ? TCC_TICKS_FASTEST : (TCC_TICKS_SLOWEST >> code);
    end else if (run_ff) begin
      if (pre_ff == PRE_LAST) begin
        nxt_pre = '0;
        nxt_ticks = ticks_ff - TCC_TICKS_FASTEST;
        if (ticks_ff == TCC_TICKS_FASTEST) begin
          nxt_run = 1'b0;
          nxt_exp = 1'b1;
        end
      end else begin
        nxt_pre = pre_ff + PRE_W'(1);
      end
    end
  end

  // Timer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= '0;
      ticks_ff <= '0;
      run_ff <= 1'b0;
      exp_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      ticks_ff <= nxt_ticks;
      run_ff <= nxt_run;
      exp_ff <= nxt_exp;
    end
  end

  // Flag the last cycle of the period too, so the next start lands exactly one period on
  assign expired = exp_ff || (run_ff && (pre_ff == PRE_LAST) && (ticks_ff == TCC_TICKS_FASTEST));
endmodule : tcc_interval_timer

/* tcc_top.sv */
// Purpose: Control and result registers of the temperature measurement engine
// Assumes: Serial target delivers decoded byte accesses on the register port
// Notes: One clock, no bus beyond the serial target's register port
module tcc_top #(
  parameter int TICK_CYCLES = tcc_pkg::TCC_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic burst_end,
  output logic [7:0] reg_rdata,
  input wire logic external_trigger_pin,
  input wire logic external_trigger_select,
  input wire logic [tcc_pkg::TCC_CODE_W-1:0] sample_interval_code,
  output logic fe_start,
  output logic fe_abort,
  input wire logic fe_done,
  input wire logic [tcc_pkg::TCC_DATA_W-1:0] fe_data,
  output logic fifo_wr,
  output logic [tcc_pkg::TCC_DATA_W-1:0] fifo_wdata
);
  import tcc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tcc_conv_if cv (); // Carrier to the conversion engine
  tcc_state_t state_ff, nxt_state; // Control state
  logic go_ff, nxt_go; // Measurement go bit
  logic auto_ff, nxt_auto; // Continuous-sampling select
  logic sync1_ff, sync2_ff, prev_ff; // Trigger pin synchroniser
  logic trig_edge; // Rising edge of the trigger pin
  logic ctrl_wr; // Write to measure_control
  logic w_go, w_auto; // Written control bits
  logic tmr_load, tmr_exp; // Interval timer handshake
  logic conv_start, conv_abort; // Requests to the engine
  logic [15:0] result_ff, nxt_result; // Latest visible sample
  logic [15:0] pend_ff, nxt_pend; // Sample held back by a burst
  logic pend_v_ff, nxt_pend_v; // Held sample waiting
  logic lock_ff, nxt_lock; // High-byte burst in progress
  logic eff_lock; // Lock still standing this cycle
  logic fifo_wr_ff, nxt_fifo_wr; // FIFO write strobe
  logic [15:0] fifo_d_ff, nxt_fifo_d; // FIFO write data
  logic [7:0] rdata_ff, nxt_rdata; // Read answer

  assign ctrl_wr = reg_wr && (reg_addr == TCC_OFS_CTRL);
  assign w_go = reg_wdata[TCC_BIT_GO];
  assign w_auto = reg_wdata[TCC_BIT_AUTO];

  // ----------------------------------------------------------------
  // Trigger pin synchroniser
  // ----------------------------------------------------------------
  // Two stages before any logic, third stage for the edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      sync1_ff <= external_trigger_pin;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end
  assign trig_edge = sync2_ff && !prev_ff;

  // ----------------------------------------------------------------
  // Conversion control
  // ----------------------------------------------------------------
  // Next state, control bits and engine requests
  always_comb begin
    nxt_state = state_ff;
    nxt_go = go_ff;
    nxt_auto = auto_ff;
    conv_start = 1'b0;
    conv_abort = 1'b0;
    tmr_load = 1'b0;
    if (ctrl_wr) begin
      nxt_auto = w_auto; // Stored even while the pin triggers
    end
    case (state_ff)
      TCC_ST_IDLE: begin
        if (external_trigger_select) begin
          if (trig_edge) begin
            conv_start = 1'b1;
            nxt_state = TCC_ST_EXT_RUN;
          end
        end else if (ctrl_wr && w_go) begin
          conv_start = 1'b1;
          nxt_go = 1'b1;
          if (w_auto) begin
            tmr_load = 1'b1;
            nxt_state = TCC_ST_AUTO_RUN;
          end else begin
            nxt_state = TCC_ST_SINGLE;
          end
        end
      end
      TCC_ST_SINGLE, TCC_ST_AUTO_RUN: begin
        if (ctrl_wr && !w_go) begin
          conv_abort = 1'b1;
          nxt_go = 1'b0;
          nxt_state = TCC_ST_IDLE;
        end else if (cv.done) begin
          if (state_ff == TCC_ST_SINGLE) begin
            nxt_go = 1'b0;
            nxt_state = TCC_ST_IDLE;
          end else begin
            nxt_state = TCC_ST_AUTO_WAIT;
          end
        end
        // A write of 1 while converting leaves go and the state unchanged
      end
      TCC_ST_AUTO_WAIT: begin
        if ((ctrl_wr && !w_go) || external_trigger_select) begin
          nxt_go = 1'b0;
          nxt_state = TCC_ST_IDLE;
        end else if (tmr_exp) begin
          conv_start = 1'b1;
          tmr_load = 1'b1;
          nxt_state = TCC_ST_AUTO_RUN;
        end
      end
      TCC_ST_EXT_RUN: begin
        if (cv.done) begin
          nxt_state = TCC_ST_IDLE;
        end
      end
      default: begin
        nxt_go = 1'b0;
        nxt_state = TCC_ST_IDLE;
      end
    endcase
  end

  // Control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= TCC_ST_IDLE;
      go_ff <= TCC_CTRL_RST;
      auto_ff <= TCC_CTRL_RST;
    end else begin
      state_ff <= nxt_state;
      go_ff <= nxt_go;
      auto_ff <= nxt_auto;
    end
  end

  assign cv.start = conv_start;
  assign cv.abort = conv_abort;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  // Front-end sequencing
  tcc_conv_engine u_engine (
    .clk(clk),
    .rst_n(rst_n),
    .cv(cv.engine),
    .fe_start(fe_start),
    .fe_abort(fe_abort),
    .fe_done(fe_done),
    .fe_data(fe_data)
  );

  // Sample period timer
  tcc_interval_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(tmr_load),
    .code(sample_interval_code),
    .expired(tmr_exp)
  );

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  assign eff_lock = lock_ff && !burst_end;

  // Result, deferral and FIFO strobe
  always_comb begin
    nxt_result = result_ff;
    nxt_pend = pend_ff;
    nxt_pend_v = pend_v_ff;
    nxt_fifo_wr = cv.done;
    nxt_fifo_d = cv.done ? cv.data : fifo_d_ff;
    // A high-byte read sets the lock until the burst ends
    nxt_lock = eff_lock || (reg_rd && (reg_addr == TCC_OFS_RES_HI));
    if (cv.done && !eff_lock) begin
      nxt_result = cv.data;
      nxt_pend_v = 1'b0;
    end else if (cv.done) begin
      nxt_pend = cv.data;
      nxt_pend_v = 1'b1;
    end else if (!eff_lock && pend_v_ff) begin
      nxt_result = pend_ff;
      nxt_pend_v = 1'b0;
    end
  end

  // Result storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_ff <= TCC_RESULT_RST;
      pend_ff <= TCC_RESULT_RST;
      pend_v_ff <= 1'b0;
      lock_ff <= 1'b0;
      fifo_wr_ff <= 1'b0;
      fifo_d_ff <= TCC_RESULT_RST;
    end else begin
      result_ff <= nxt_result;
      pend_ff <= nxt_pend;
      pend_v_ff <= nxt_pend_v;
      lock_ff <= nxt_lock;
      fifo_wr_ff <= nxt_fifo_wr;
      fifo_d_ff <= nxt_fifo_d;
    end
  end

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------
  // Registered read data, zero for offsets this block does not own
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      case (reg_addr)
        TCC_OFS_CTRL: begin
          nxt_rdata = TCC_RD_ZERO;
          nxt_rdata[TCC_BIT_GO] = go_ff;
          nxt_rdata[TCC_BIT_AUTO] = auto_ff;
        end
        TCC_OFS_RES_HI: nxt_rdata = result_ff[15:8];
        TCC_OFS_RES_LO: nxt_rdata = result_ff[7:0];
        default: nxt_rdata = TCC_RD_ZERO;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= TCC_RD_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign fifo_wr = fifo_wr_ff;
  assign fifo_wdata = fifo_d_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_AUTO_START: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == TCC_ST_IDLE && !external_trigger_select && ctrl_wr && w_go && w_auto)
    |=> (state_ff == TCC_ST_AUTO_RUN) ##1 cv.busy)
    else $error("continuous start did not begin a conversion");
  AST_SINGLE_START: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == TCC_ST_IDLE && !external_trigger_select && ctrl_wr && w_go && !w_auto)
    |=> state_ff == TCC_ST_SINGLE && go_ff && fe_start)
    else $error("single start did not begin one conversion");
  AST_EXT_IGNORES_GO: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == TCC_ST_IDLE && external_trigger_select && ctrl_wr) |=> !go_ff)
    else $error("go bit acted while trigger pin selected");
  AST_SINGLE_DONE: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == TCC_ST_SINGLE && cv.done && !ctrl_wr) |=> !go_ff && state_ff == TCC_ST_IDLE)
    else $error("go bit not cleared after single conversion");
  AST_ABORT: assert property (@(posedge clk) disable iff (!rst_n)
    ((state_ff == TCC_ST_SINGLE || state_ff == TCC_ST_AUTO_RUN) && ctrl_wr && !w_go)
    |=> fe_abort && !go_ff ##1 !cv.busy)
    else $error("abort did not reach the front end");
  AST_STOPPED: assert property (@(posedge clk) disable iff (!rst_n)
    (!go_ff && state_ff != TCC_ST_EXT_RUN) |-> state_ff == TCC_ST_IDLE)
    else $error("conversion running with go bit clear");
  AST_BUSY_IGNORE: assert property (@(posedge clk) disable iff (!rst_n)
    (go_ff && ctrl_wr && w_go && !cv.done && state_ff != TCC_ST_AUTO_WAIT)
    |=> go_ff && state_ff == $past(state_ff) && !fe_start)
    else $error("go write of 1 acted while busy");
  AST_READ_HI: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == TCC_OFS_RES_HI) |=> reg_rdata == 8'($past(result_ff) >> 8))
    else $error("high result byte read wrong");
  AST_FIFO: assert property (@(posedge clk) disable iff (!rst_n)
    cv.done |=> fifo_wr && fifo_wdata == $past(cv.data))
    else $error("result not written to FIFO");
  AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (lock_ff && !burst_end) |=> $stable(result_ff))
    else $error("result changed during high-byte burst");
endmodule : tcc_top

/* tcc_fe_model.sv */
// Purpose: Behavioural analog front end that answers the conversion control block
// Assumes: Same clock as the block; one conversion at a time
// Notes: Latency and sample value come from the bench; data scrambles when not valid
module tcc_fe_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fe_start,
  input wire logic fe_abort,
  input wire logic [7:0] lat,
  input wire logic [15:0] sample,
  output logic fe_done,
  output logic [15:0] fe_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------
  logic busy_ff; // Conversion outstanding
  logic [7:0] cnt_ff; // Cycles left until done
  // Counts down the latency; data inverts each cycle outside the done pulse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      cnt_ff <= 8'h00;
      fe_done <= 1'b0;
      fe_data <= 16'h0000;
    end else begin
      fe_done <= 1'b0;
      fe_data <= ~fe_data;
      if (fe_abort) begin
        busy_ff <= 1'b0;
      end else if (fe_start) begin
        busy_ff <= 1'b1;
        cnt_ff <= lat;
      end else if (busy_ff) begin
        if (cnt_ff <= 8'h01) begin
          busy_ff <= 1'b0;
          fe_done <= 1'b1;
          fe_data <= sample;
        end else begin
          cnt_ff <= cnt_ff - 8'h01;
        end
      end
    end
  end
endmodule : tcc_fe_model

/* tb_top.sv */
// Purpose: Self-checking bench of the temperature conversion control block
// Assumes: Byte register port driven at the falling edge
// Notes: Base period shortened to 4 cycles
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tcc_pkg::*;
  localparam int TICKS = 4; // Shortened base period
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic burst_end = 1'b0;
  logic [7:0] reg_rdata;
  logic ext_pin = 1'b0;
  logic ext_sel = 1'b0;
  logic [3:0] code = 4'h9;
  logic fe_start, fe_abort, fe_done, fifo_wr;
  logic [15:0] fe_data, fifo_wdata;
  logic [7:0] lat = 8'h05; // Front end latency
  logic [15:0] sample = 16'h1234; // Next converted value
  int err_count = 0;
  int compares = 0;
  int cyc = 0; // Cycle counter for timeout and spacing
  int fs_cnt = 0, fa_cnt = 0, fw_cnt = 0, prev_st = 0, last_st = 0;
  int base, fbase;
  // ----------------------------------------------------------------
  // Design, front end and clock
  // ----------------------------------------------------------------
  tcc_top #(.TICK_CYCLES(TICKS)) uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .burst_end(burst_end),
    .reg_rdata(reg_rdata), .external_trigger_pin(ext_pin),
    .external_trigger_select(ext_sel), .sample_interval_code(code), .fe_start(fe_start),
    .fe_abort(fe_abort), .fe_done(fe_done), .fe_data(fe_data), .fifo_wr(fifo_wr),
    .fifo_wdata(fifo_wdata));
  tcc_fe_model fe (.clk(clk), .rst_n(rst_n), .fe_start(fe_start), .fe_abort(fe_abort),
    .lat(lat), .sample(sample), .fe_done(fe_done), .fe_data(fe_data));
  always #5 clk = ~clk;
  // Counts pulses of the block and cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (fe_start === 1'b1) begin
      fs_cnt++;
      prev_st = last_st;
      last_st = cyc;
    end
    if (fe_abort === 1'b1) fa_cnt++;
    if (fifo_wr === 1'b1) begin
      fw_cnt++;
      if (fifo_wdata !== sample) begin
        err_count++;
        $display("[FAIL] fifo_wdata exp %h got %h", sample, fifo_wdata);
      end
    end
    if (cyc == 4000) begin
      err_count++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Access and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    chk(nm, {8'h00, exp}, {8'h00, reg_rdata});
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic wait_fw(input int n);
    for (int i = 0; i < 300 && fw_cnt < n; i++) @(negedge clk);
    idle(1);
    chk("fifo writes", 16'(n), 16'(fw_cnt));
  endtask : wait_fw
  // Ends a serial transaction, which releases the result lock
  task automatic bend();
    burst_end = 1'b1;
    @(negedge clk);
    burst_end = 1'b0;
  endtask : bend
  task automatic endt(input string nm);
    $display("test %s done", nm);
  endtask : endt
  task automatic test_done();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    idle(1);
    rd(TCC_OFS_CTRL, 8'h00, "ctrl reset");
    rd(TCC_OFS_RES_HI, 8'h00, "res hi reset");
    rd(TCC_OFS_RES_LO, 8'h00, "res lo reset");
    wr(TCC_OFS_RES_HI, 8'h5A);
    rd(TCC_OFS_RES_HI, 8'h00, "res hi ro");
    rd(8'h2D, 8'h00, "unmapped");
    bend();
    endt("reset");
    // Single shot with a second go write while busy
    base = fs_cnt;
    lat = 8'h0A;
    wr(TCC_OFS_CTRL, 8'h01);
    rd(TCC_OFS_CTRL, 8'h01, "go busy");
    wr(TCC_OFS_CTRL, 8'h01);
    wait_fw(1);
    idle(30);
    chk("single starts", 16'h0001, 16'(fs_cnt - base));
    rd(TCC_OFS_CTRL, 8'h00, "go cleared");
    rd(TCC_OFS_RES_HI, 8'h12, "res hi");
    rd(TCC_OFS_RES_LO, 8'h34, "res lo");
    bend();
    endt("single");
    // Abort in mid conversion
    base = fa_cnt;
    lat = 8'h14;
    wr(TCC_OFS_CTRL, 8'h01);
    idle(3);
    wr(TCC_OFS_CTRL, 8'h00);
    idle(40);
    chk("abort pulses", 16'h0001, 16'(fa_cnt - base));
    chk("abort no sample", 16'h0001, 16'(fw_cnt));
    rd(TCC_OFS_CTRL, 8'h00, "go after abort");
    endt("abort");
    // Continuous at code 8, period of two base periods
    lat = 8'h02;
    code = 4'h8;
    wr(TCC_OFS_CTRL, 8'h03);
    wait_fw(4);
    chk("period", 16'(2 * TICKS), 16'(last_st - prev_st));
    rd(TCC_OFS_CTRL, 8'h03, "auto running");
    code = 4'h9;
    wr(TCC_OFS_CTRL, 8'h00);
    idle(20);
    base = fw_cnt;
    rd(TCC_OFS_CTRL, 8'h00, "auto stopped");
    idle(40);
    chk("auto halted", 16'(base), 16'(fw_cnt));
    endt("continuous");
    // Trigger pin selected: go and continuous ignored
    ext_sel = 1'b1;
    idle(2);
    base = fs_cnt;
    wr(TCC_OFS_CTRL, 8'h01);
    idle(20);
    wr(TCC_OFS_CTRL, 8'h03);
    idle(20);
    chk("ext no start", 16'h0000, 16'(fs_cnt - base));
    fbase = fw_cnt;
    ext_pin = 1'b1;
    idle(6);
    ext_pin = 1'b0;
    wait_fw(fbase + 1);
    chk("ext one start", 16'h0001, 16'(fs_cnt - base));
    wr(TCC_OFS_CTRL, 8'h00);
    ext_sel = 1'b0;
    idle(10);
    endt("trigger");
    // Result kept whole while a burst from the high byte runs
    lat = 8'h0A;
    base = fw_cnt;
    wr(TCC_OFS_CTRL, 8'h01);
    rd(TCC_OFS_RES_HI, 8'h12, "burst hi");
    sample = 16'hBEEF;
    wait_fw(base + 1);
    rd(TCC_OFS_RES_LO, 8'h34, "burst lo held");
    bend();
    idle(1);
    rd(TCC_OFS_RES_HI, 8'hBE, "new hi");
    rd(TCC_OFS_RES_LO, 8'hEF, "new lo");
    endt("burst");
    test_done();
  end
endmodule : tb_top
